// ---- adc_8bit_control.sv ----
// Operation
// [R1] A conversion lasts exactly 64 clock cycles, the first 31.5 of which sample the selected input; here sampling is rounded up to 32 cycles.
// [R2] An input at or above the high reference yields code FFh with no overflow indication.
// [R3] An input at or below the low reference yields code 00h.
// [R4] The result is linear, 255 times the input over the reference span.
// [R5] After power on a stabilization wait of typically 30 us passes, then conversions run back to back.
// [R6] A finished conversion loads the result register and sets the done flag in bit 7 with no interrupt; here done raises irq if irq_enable bit 0 is set.
// [R7] Any write to the control/status register aborts the conversion, clears the done flag and restarts.
// [R8] Reading the result register clears the done flag.
// [R9] Bits 2 to 0 of the control/status register select analog input 0 to 7.
// [R10] Bit 5 turns the converter on, and while it is zero no conversion runs.
// [R11] Bit 4 of the control/status register always reads zero.
// [R12] Software always writes zero to bits 6 and 3.
// [R13] Wait mode does not affect the converter.
// [R14] Halt mode disables the converter, and after wakeup the stabilization wait is needed again.
// [R15] The result register is read-only, eight bits wide and resets to zero.
// [R16] Each conversion overwrites the result, and the done flag holds until cleared by software.
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module adc_8bit_control
#(
	parameter int stab_cycles = adc_8bit_pkg::stab_cycles
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        halt_mode,
	input  wire logic        comparator_high,
	output var  logic [2:0]  input_channel_select,
	output logic             analog_power,
	output logic             sample_enable,
	output logic [7:0]       trial_code,
	output logic             irq
);
	localparam int stab_width = $clog2(stab_cycles + 1);

	sar_if sar ();

	logic                  converter_power_on;
	logic                  conversion_done_flag;
	logic [7:0]            conversion_result;
	logic                  powered;
	logic                  ready;
	logic [stab_width-1:0] stab_count;
	logic                  ready_rise;
	logic                  comp_meta;
	logic                  comp_sync;
	logic                  wr_pending;
	logic [11:0]           wr_addr;
	logic                  take;
	logic                  rd_take;
	logic                  csr_write;
	logic                  result_read;
	logic [adc_8bit_pkg::irq_width-1:0] irq_status;
	logic [adc_8bit_pkg::irq_width-1:0] irq_enable;
	logic [adc_8bit_pkg::irq_width-1:0] irq_events;
	logic [adc_8bit_pkg::irq_width-1:0] irq_clear;
	logic [31:0]           next_hrdata;

	function automatic logic is_addr(input logic [31:0] a, input logic [11:0] off);
		is_addr = (a[11:0] == off);
	endfunction : is_addr

	// address phase accepted; only whole-word single transfers are expected
	assign take    = hsel && hready && htrans == adc_8bit_pkg::htrans_nonseq;
	assign rd_take = take && !hwrite;

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pending <= 1'b0;
			wr_addr    <= 12'h000;
		end
		else
		begin
			wr_pending <= take && hwrite;
			wr_addr    <= haddr[11:0];
		end
	end

	assign csr_write   = wr_pending && wr_addr == adc_8bit_pkg::ctrl_status_off; // see [R7]
	assign result_read = rd_take && is_addr(haddr, adc_8bit_pkg::result_off); // see [R8]

	// software fields of the control/status register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			converter_power_on   <= 1'b0;
			input_channel_select <= adc_8bit_pkg::reg_reset[2:0];
		end
		else if (csr_write)
		begin
			// bits 6 and 3 are expected zero from software and are not stored
			converter_power_on   <= hwdata[adc_8bit_pkg::power_bit]; // see [R10] see [R12]
			input_channel_select <=
				hwdata[adc_8bit_pkg::chan_hi_bit:adc_8bit_pkg::chan_lo_bit]; // see [R9]
		end
	end

	// halt removes power; wait mode has no input here at all
	assign powered      = converter_power_on && !halt_mode; // see [R10] see [R13] see [R14]
	assign analog_power = powered;

	// stabilization restarts on every power-up, including halt wakeup
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stab_count <= '0;
			ready      <= 1'b0;
		end
		else if (!powered)
		begin
			stab_count <= '0; // see [R14]
			ready      <= 1'b0;
		end
		else if (!ready)
		begin
			if (stab_count == stab_width'(stab_cycles - 1))
				ready <= 1'b1; // see [R5]
			else
				stab_count <= stab_count + stab_width'(1);
		end
	end

	assign ready_rise = powered && !ready && stab_count == stab_width'(stab_cycles - 1);

	// comparator comes from the analog core, asynchronous to hclk
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			comp_meta <= 1'b0;
			comp_sync <= 1'b0;
		end
		else
		begin
			comp_meta <= comparator_high;
			comp_sync <= comp_meta;
		end
	end

	assign sar.run       = ready && powered; // see [R5] see [R10]
	assign sar.restart   = csr_write; // see [R7]
	assign sar.comp_high = comp_sync;

	sar_sequencer u_seq
	(
		.hclk    (hclk),
		.hresetn (hresetn),
		.sar     (sar)
	);

	assign sample_enable = sar.sample;
	assign trial_code    = sar.trial_code;

	// the sequencer's result flop is the register; a second copy on done would lag one conversion
	assign conversion_result = sar.result; // see [R6] see [R15] see [R16]

	// a finishing conversion wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			conversion_done_flag <= 1'b0;
		else if (sar.done)
			conversion_done_flag <= 1'b1; // see [R6] see [R16]
		else if (result_read || csr_write)
			conversion_done_flag <= 1'b0; // see [R7] see [R8]
	end

	// optional system interrupt, disabled from reset so the converter stays silent
	assign irq_events[adc_8bit_pkg::irq_done_bit]  = sar.done;
	assign irq_events[adc_8bit_pkg::irq_ready_bit] = ready_rise;
	assign irq_clear = (wr_pending && wr_addr == adc_8bit_pkg::irq_clear_off)
		? hwdata[adc_8bit_pkg::irq_width-1:0] : '0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_status <= '0;
		else
			irq_status <= irq_events | (irq_status & ~irq_clear);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_enable <= '0;
		else if (wr_pending && wr_addr == adc_8bit_pkg::irq_enable_off)
			irq_enable <= hwdata[adc_8bit_pkg::irq_width-1:0];
	end

	assign irq = |(irq_status & irq_enable); // see [R6]

	// read mux sampled at the address phase so data stand from a flop
	always_comb
	begin
		next_hrdata = 32'h0000_0000;
		if (is_addr(haddr, adc_8bit_pkg::ctrl_status_off))
		begin
			next_hrdata[adc_8bit_pkg::done_bit]  = conversion_done_flag;
			next_hrdata[adc_8bit_pkg::power_bit] = converter_power_on;
			next_hrdata[adc_8bit_pkg::zero_bit]  = 1'b0; // see [R11]
			next_hrdata[adc_8bit_pkg::chan_hi_bit:adc_8bit_pkg::chan_lo_bit] = input_channel_select;
		end
		else if (is_addr(haddr, adc_8bit_pkg::result_off))
			next_hrdata[adc_8bit_pkg::data_width-1:0] = conversion_result; // see [R15]
		else if (is_addr(haddr, adc_8bit_pkg::irq_status_off))
			next_hrdata[adc_8bit_pkg::irq_width-1:0] = irq_status;
		else if (is_addr(haddr, adc_8bit_pkg::irq_enable_off))
			next_hrdata[adc_8bit_pkg::irq_width-1:0] = irq_enable;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (rd_take)
			hrdata <= next_hrdata;
	end
endmodule : adc_8bit_control
`default_nettype wire

// ---- adc_8bit_control_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_8bit_control_checker
#(
	parameter int stab_cycles = adc_8bit_pkg::stab_cycles
)
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        halt_mode,
	input wire logic [2:0]  input_channel_select,
	input wire logic        analog_power,
	input wire logic        sample_enable,
	input wire logic [7:0]  trial_code
);
	logic rd_csr;
	logic wr_csr;

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			rd_csr <= 1'b0;
		else if (hsel && htrans == 2'h2 && !hwrite)
			rd_csr <= haddr[11:0] == 12'h000;

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			wr_csr <= 1'b0;
		else
			wr_csr <= hsel && htrans == 2'h2 && hwrite && haddr[11:0] == 12'h000;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_halt_off: assert property (halt_mode |-> !analog_power)
		else $error("converter powered in halt");
	a_off_idle: assert property (!analog_power |-> !sample_enable)
		else $error("sampling while off");
	a_msb_trial: assert property ($fell(sample_enable) && analog_power |-> trial_code == 8'h80)
		else $error("first trial code wrong");
	a_code_zero: assert property (sample_enable |-> trial_code == 8'h00)
		else $error("trial code set while sampling");
	a_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_csr_zeros: assert property (rd_csr |-> !hrdata[6] && !hrdata[4] && !hrdata[3])
		else $error("reserved bit reads one");
	a_chan_write: assert property (wr_csr |=> input_channel_select == $past(hwdata[2:0]))
		else $error("channel not taken");
	a_power_write: assert property (wr_csr |=> analog_power == ($past(hwdata[5]) && !halt_mode))
		else $error("power bit not applied");
	a_resp_okay: assert property (!hresp)
		else $error("error response on bus");
endmodule : adc_8bit_control_checker
bind adc_8bit_control adc_8bit_control_checker #(.stab_cycles(stab_cycles)) adc_8bit_control_checker_i
(
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hrdata, .hresp, .halt_mode,
	.input_channel_select, .analog_power, .sample_enable, .trial_code
);
`default_nettype wire

// ---- adc_8bit_pkg.sv ----
package adc_8bit_pkg;

	// register byte offsets
	localparam logic [11:0] ctrl_status_off = 12'h000;
	localparam logic [11:0] result_off      = 12'h004;
	localparam logic [11:0] irq_status_off  = 12'h008;
	localparam logic [11:0] irq_clear_off   = 12'h00C;
	localparam logic [11:0] irq_enable_off  = 12'h010;

	// control/status field positions
	localparam int done_bit    = 7;
	localparam int power_bit   = 5;
	localparam int zero_bit    = 4;
	localparam int chan_hi_bit = 2;
	localparam int chan_lo_bit = 0;
	localparam int chan_width  = 3;
	localparam int data_width  = 8;

	// interrupt event bits
	localparam int irq_done_bit  = 0;
	localparam int irq_ready_bit = 1;
	localparam int irq_width     = 2;

	localparam logic [7:0] reg_reset = 8'h00;

	// conversion timing in hclk cycles
	localparam int conv_cycles        = 64;
	localparam int sample_half_cycles = 63;
	localparam int sample_cycles      = (sample_half_cycles + 1) / 2;
	localparam int step_cycles        = (conv_cycles - sample_cycles) / data_width;

	// stabilization after power on, typical figure
	localparam int stab_time_ns  = 30000;
	localparam int clk_period_ns = 20;
	localparam int stab_cycles   = stab_time_ns / clk_period_ns;

	localparam logic [1:0] htrans_nonseq = 2'h2;

endpackage : adc_8bit_pkg

// ---- analog_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module analog_model
(
	input  wire logic       hclk,
	input  wire logic [2:0] input_channel_select,
	input  wire logic [7:0] trial_code,
	input  wire logic       analog_power,
	input  wire logic       sample_enable,
	output logic            comparator_high
);
	logic [7:0] level [8];
	logic [7:0] held;
	logic       toggle = 1'b0;

	// track while sampling, hold for the whole approximation phase
	always_ff @(posedge hclk)
	begin
		toggle <= !toggle;
		if (sample_enable)
			held <= level[input_channel_select];
	end

	// unpowered core gives garbage, not a tidy last value
	assign comparator_high = analog_power ? (held >= trial_code) : toggle;
endmodule : analog_model
`default_nettype wire

// ---- sar_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface sar_if;
	logic       run;
	logic       restart;
	logic       comp_high;
	logic       sample;
	logic [7:0] trial_code;
	logic       done;
	logic [7:0] result;

	modport ctrl
	(
		output run,
		output restart,
		output comp_high,
		input  sample,
		input  trial_code,
		input  done,
		input  result
	);

	modport engine
	(
		input  run,
		input  restart,
		input  comp_high,
		output sample,
		output trial_code,
		output done,
		output result
	);
endinterface : sar_if
`default_nettype wire

// ---- sar_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module sar_sequencer
(
	input  wire logic hclk,
	input  wire logic hresetn,
	sar_if.engine     sar
);
	logic [5:0] cycle;
	logic [7:0] code;
	logic [2:0] bit_idx;
	logic       deciding;
	logic [7:0] resolved;

	// bit under trial after the sampling window, msb first
	assign bit_idx  = 3'(7 - int'(cycle[4:2]));
	assign deciding = (cycle >= 6'(adc_8bit_pkg::sample_cycles))
		&& (cycle[1:0] == 2'(adc_8bit_pkg::step_cycles - 1));

	always_comb
	begin
		resolved = code;
		if (!sar.comp_high)
			resolved[bit_idx] = 1'b0; // see [R2] see [R3] see [R4]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cycle <= '0;
		else if (!sar.run || sar.restart)
			cycle <= '0;
		else
			cycle <= cycle + 6'h01; // see [R1] see [R5]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			code <= 8'h00;
		// cleared on done too, so the next sampling window never shows the last trial code
		else if (!sar.run || sar.restart || sar.done || cycle < 6'(adc_8bit_pkg::sample_cycles - 1))
			code <= 8'h00;
		else if (cycle == 6'(adc_8bit_pkg::sample_cycles - 1))
			code <= 8'h80;
		else if (deciding && bit_idx != 3'h0)
			code <= resolved | (8'h01 << (bit_idx - 3'h1));
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sar.result <= 8'h00;
		else if (sar.done)
			sar.result <= resolved;
	end

	// sampling covers the half cycle too, rounded up
	assign sar.sample     = sar.run && cycle < 6'(adc_8bit_pkg::sample_cycles); // see [R1]
	assign sar.trial_code = code;
	assign sar.done       = sar.run && !sar.restart
		&& cycle == 6'(adc_8bit_pkg::conv_cycles - 1); // see [R1]
endmodule : sar_sequencer
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, halt_mode = 0, rd_dp = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2, input_channel_select;
	logic [7:0]  code, trial_code;
	logic        hreadyout, hresp, comparator_high, analog_power, sample_enable, irq;
	logic [31:0] exp_q [$];
	int          err_count = 0, checked = 0, cycles = 0;

	always #10 hclk = ~hclk;

	// short stabilization keeps the run brief
	adc_8bit_control #(.stab_cycles(20)) adc_8bit_control_i
	(
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .halt_mode, .comparator_high, .input_channel_select, .analog_power,
		.sample_enable, .trial_code, .irq
	);
	analog_model analog_model_i
	(
		.hclk, .input_channel_select, .trial_code, .analog_power, .sample_enable, .comparator_high
	);

	task final_report();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// irq is sampled mid-cycle, well away from the edge that updates it
	task chk_irq(input logic exp);
		@(negedge hclk);
		checked++;
		if (irq !== exp)
		begin
			err_count++;
			$display("BAD %0t irq %b expected %b", $time, irq, exp);
		end
		@(posedge hclk);
	endtask : chk_irq

	// one single transfer; a read notes its expected data for the monitor
	task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !w;
		if (!w)
			exp_q.push_back(d);
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd_dp <= 1'b0;
	endtask : xfer

	always @(posedge hclk)
		if (rd_dp)
			chk(hrdata, exp_q.pop_front());

	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			final_report();
		end
	end

	initial
	begin
		void'($urandom(32'h3ECD));
		for (int i = 2; i < 8; i++)
			analog_model_i.level[i] = 8'($urandom);
		analog_model_i.level[0] = 8'hFF;
		analog_model_i.level[1] = 8'h00;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(12'h000, 1'b0, 32'h0);
		xfer(12'h004, 1'b0, 32'h0);
		xfer(12'h020, 1'b0, 32'h0);
		xfer(12'h010, 1'b0, 32'h0);
		xfer(12'h010, 1'b1, 32'h3);
		xfer(12'h000, 1'b1, 32'h30);
		repeat (100) @(posedge hclk);
		chk_irq(1'b1);
		xfer(12'h008, 1'b0, 32'h3);
		xfer(12'h00C, 1'b1, 32'h3);
		xfer(12'h008, 1'b0, 32'h0);
		chk_irq(1'b0);
		xfer(12'h010, 1'b1, 32'h0);
		repeat (70) @(posedge hclk);
		chk_irq(1'b0);
		xfer(12'h008, 1'b0, 32'h1);
		for (int n = 0; n < 8; n++)
		begin
			code = analog_model_i.level[n];
			xfer(12'h000, 1'b1, 32'h30 | n);
			repeat (55) @(posedge hclk);
			xfer(12'h000, 1'b0, 32'h20 | n);
			repeat (10) @(posedge hclk);
			xfer(12'h000, 1'b0, 32'hA0 | n);
			xfer(12'h004, 1'b0, {24'h0, code});
			xfer(12'h000, 1'b0, 32'h20 | n);
		end
		// halt drops power but keeps the programmed power bit
		halt_mode <= 1'b1;
		repeat (100) @(posedge hclk);
		xfer(12'h000, 1'b0, 32'h27);
		halt_mode <= 1'b0;
		// without a fresh stabilization wait a conversion would have finished by now
		repeat (72) @(posedge hclk);
		xfer(12'h000, 1'b0, 32'h27);
		repeat (40) @(posedge hclk);
		xfer(12'h000, 1'b0, 32'hA7);
		xfer(12'h000, 1'b1, 32'h0);
		repeat (100) @(posedge hclk);
		xfer(12'h000, 1'b0, 32'h0);
		xfer(12'h004, 1'b0, {24'h0, analog_model_i.level[7]});
		final_report();
	end
endmodule : testbench
`default_nettype wire
